// ---- include/qdr_pkg.sv ----
// Package with constants for the quad DAC two-wire readback slave.
package qdr_pkg;
    localparam logic [4:0] ADDR_FIXED = 5'h13;
    localparam int CHAN_COUNT = 4;
    localparam int DATA_W = 8;
    localparam int PD_W = 2;
    localparam logic [5:0] PD_FILL = 6'h3F;
    localparam logic [7:0] LOW_FILL = 8'h00;
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam logic PD_FLAG_RESET = 1'b0;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [1:0] BYTES_NORMAL = 2'h2;
    localparam logic [1:0] BYTES_PWRDN = 2'h3;
    typedef enum logic [2:0] {
        QDR_IDLE, QDR_ADDR, QDR_CTRL, QDR_WDATA, QDR_TX, QDR_RXACK, QDR_HOLD
    } qdr_state_t;
endpackage

// ---- rtl/qdr_slave.sv ----
// Two-wire slave that acknowledges addressing and control and transmits channel readback bytes.
`timescale 1ns/1ps
module qdr_slave (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Two-wire bus pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Strap and channel contents
    input wire logic [1:0] hwAddr,
    input wire logic [qdr_pkg::CHAN_COUNT*qdr_pkg::DATA_W-1:0] chanData,
    input wire logic [qdr_pkg::CHAN_COUNT*qdr_pkg::PD_W-1:0] chanPwrdn,
    // Status of the latched control byte
    output logic [1:0] chanSel,
    output logic powerDownFlag,
    output logic [1:0] loadMode,
    output logic [1:0] extAddr
);
    import qdr_pkg::*;

    typedef struct packed {
        logic [1:0] sclSync;
        logic [1:0] sdaSync;
        logic sclPrev;
        logic sdaPrev;
        qdr_state_t state;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [1:0] byteIdx;
        logic [1:0] chanSel;
        logic powerDownFlag;
        logic [1:0] loadMode;
        logic [1:0] extAddr;
        logic sdaOut;
        logic sdaOe;
    } qdr_regs_t;

    qdr_regs_t r;
    qdr_regs_t next_r;

    logic scl;
    logic sda;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic [7:0] rxByte;
    logic [1:0] byteTotal;
    logic [7:0] txByte;

    assign scl = r.sclSync[1];
    assign sda = r.sdaSync[1];
    assign sclRise = scl && !r.sclPrev;
    assign sclFall = !scl && r.sclPrev;
    assign startSeen = scl && r.sclPrev && r.sdaPrev && !sda;
    assign stopSeen = scl && r.sclPrev && !r.sdaPrev && sda;
    assign rxByte = {r.shift[6:0], sda};
    assign byteTotal = r.powerDownFlag ? BYTES_PWRDN : BYTES_NORMAL;

    // The byte loaded is chosen by position; the low byte carries only the LOW_FILL constant.
    always_comb begin
        logic [1:0] pos;
        pos = r.powerDownFlag ? r.byteIdx : r.byteIdx + 2'h1;
        unique case (pos)
            2'h0: txByte = {chanPwrdn[r.chanSel*PD_W +: PD_W], PD_FILL};
            2'h1: txByte = chanData[r.chanSel*DATA_W +: DATA_W];
            default: txByte = LOW_FILL;
        endcase
    end

    always_comb begin
        next_r = r;
        next_r.sclSync = {r.sclSync[0], sclIn};
        next_r.sdaSync = {r.sdaSync[0], sdaIn};
        next_r.sclPrev = scl;
        next_r.sdaPrev = sda;
        if (startSeen) begin
            // A repeated start always returns to addressing and lets go of the line.
            next_r.state = QDR_ADDR;
            next_r.bitCnt = 4'h0;
            next_r.sdaOe = 1'b0;
        end else if (stopSeen) begin
            next_r.state = QDR_IDLE;
            next_r.sdaOe = 1'b0;
        end else begin
            unique case (r.state)
                QDR_IDLE, QDR_HOLD: begin
                    next_r.sdaOe = 1'b0;
                end
                QDR_ADDR, QDR_CTRL, QDR_WDATA: begin
                    if (sclRise && r.bitCnt <= BIT_LAST) begin
                        next_r.shift = rxByte;
                        next_r.bitCnt = r.bitCnt + 4'h1;
                    end else if (sclFall && r.bitCnt == BIT_ACK) begin
                        // The acknowledge clock must not be shifted in as a data bit, so the count parks past the byte.
                        next_r.bitCnt = BIT_ACK + 4'h1;
                        next_r.sdaOe = 1'b0;
                        if (r.state == QDR_ADDR) begin
                            if (r.shift[7:3] == ADDR_FIXED && r.shift[2:1] == hwAddr) begin
                                next_r.sdaOe = 1'b1;
                                next_r.sdaOut = 1'b0;
                                next_r.byteIdx = 2'h0;
                                next_r.state = r.shift[0] ? QDR_TX : QDR_CTRL;
                                // Transmit counts its own bits from the acknowledge clock's falling edge.
                                next_r.bitCnt = r.shift[0] ? 4'h0 : BIT_ACK + 4'h1;
                            end else begin
                                next_r.state = QDR_HOLD;
                            end
                        end else if (r.state == QDR_CTRL) begin
                            next_r.extAddr = r.shift[7:6];
                            next_r.loadMode = r.shift[5:4];
                            next_r.chanSel = r.shift[2:1];
                            next_r.powerDownFlag = r.shift[0];
                            next_r.sdaOe = 1'b1;
                            next_r.sdaOut = 1'b0;
                            next_r.state = QDR_WDATA;
                        end else begin
                            // Write data bytes belong to another path; this one only acknowledges.
                            next_r.sdaOe = 1'b1;
                            next_r.sdaOut = 1'b0;
                        end
                    end else if (sclFall && r.bitCnt == BIT_ACK + 4'h1) begin
                        next_r.sdaOe = 1'b0;
                        next_r.bitCnt = 4'h0;
                    end
                end
                QDR_TX: begin
                    if (sclFall) begin
                        if (r.bitCnt == 4'h0) begin
                            next_r.shift = {txByte[6:0], 1'b0};
                            next_r.sdaOut = txByte[7];
                            next_r.sdaOe = 1'b1;
                            next_r.bitCnt = 4'h1;
                        end else if (r.bitCnt == BIT_ACK) begin
                            next_r.sdaOe = 1'b0;
                            next_r.state = QDR_RXACK;
                        end else begin
                            next_r.sdaOut = r.shift[7];
                            next_r.shift = {r.shift[6:0], 1'b0};
                            next_r.bitCnt = r.bitCnt + 4'h1;
                        end
                    end
                end
                QDR_RXACK: begin
                    if (sclRise) begin
                        next_r.bitCnt = 4'h0;
                        if (sda || r.byteIdx + 2'h1 >= byteTotal) begin
                            next_r.state = QDR_HOLD;
                        end else begin
                            next_r.byteIdx = r.byteIdx + 2'h1;
                            next_r.state = QDR_TX;
                        end
                    end
                end
                default: next_r.state = QDR_IDLE;
            endcase
            if (r.state == QDR_TX && sclFall && r.bitCnt == 4'h0) begin
                next_r.bitCnt = 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            r <= '{sclSync: 2'h3, sdaSync: 2'h3, sclPrev: 1'b1, sdaPrev: 1'b1, state: QDR_IDLE,
                   bitCnt: 4'h0, shift: 8'h00, byteIdx: 2'h0, chanSel: SEL_RESET,
                   powerDownFlag: PD_FLAG_RESET, loadMode: 2'h0, extAddr: 2'h0,
                   sdaOut: 1'b1, sdaOe: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign sdaOut = r.sdaOut;
    assign sdaOe = r.sdaOe;
    assign chanSel = r.chanSel;
    assign powerDownFlag = r.powerDownFlag;
    assign loadMode = r.loadMode;
    assign extAddr = r.extAddr;

    ack_on_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (r.state == QDR_ADDR && sclFall && r.bitCnt == BIT_ACK && r.shift[7:3] == ADDR_FIXED
         && r.shift[2:1] == hwAddr) |=> (sdaOe && !sdaOut))
        else $error("address match not acknowledged");
    addr_mismatch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (r.state == QDR_ADDR && sclFall && r.bitCnt == BIT_ACK && r.shift[7:3] != ADDR_FIXED)
         |=> !sdaOe)
        else $error("foreign address acknowledged");
    ack_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ((r.state == QDR_CTRL || r.state == QDR_WDATA) && sclFall && r.bitCnt == BIT_ACK + 4'h1)
         |=> !sdaOe)
        else $error("acknowledge held past its clock");
    ctrl_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (r.state == QDR_CTRL && sclFall && r.bitCnt == BIT_ACK && !startSeen && !stopSeen)
         |=> (chanSel == $past(r.shift[2:1]) && powerDownFlag == $past(r.shift[0])))
        else $error("control byte not latched");
    byte_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (r.state == QDR_RXACK && sclRise && !sda && !startSeen && !stopSeen
         && r.byteIdx == 2'h1 && !powerDownFlag) |=> r.state == QDR_HOLD)
        else $error("too many bytes with flag clear");
    pd_fill_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (r.state == QDR_TX && sclFall && r.bitCnt == 4'h0 && powerDownFlag && r.byteIdx == 2'h0
         && !startSeen && !stopSeen) |=> r.shift[6:1] == PD_FILL)
        else $error("power-down byte fill wrong");
    hold_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (r.state == QDR_HOLD) |=> !sdaOe)
        else $error("SDA driven after readback end");
    stop_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        stopSeen |=> (!sdaOe && r.state == QDR_IDLE))
        else $error("stop did not release bus");
    nack_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (r.state == QDR_RXACK && sclRise && sda && !startSeen && !stopSeen)
         |=> (r.state == QDR_HOLD) ##1 !sdaOe)
        else $error("nack did not end transmit");
endmodule

// ---- tb/qdr_master.sv ----
// Behavioural two-wire bus master that opens, addresses, reads and closes transfers.
`timescale 1ns/1ps
module qdr_master (
    // Clock
    input wire logic sys_clk,
    // Bus pins, data pulled low while sdaPull is high
    input wire logic sdaBus,
    output logic sclOut,
    output logic sdaPull
);
    initial begin
        sclOut = 1'b1;
        sdaPull = 1'b0;
    end
    task automatic waitClk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Data moves only while the clock is low, so no start or stop is made by accident.
    task automatic busBit(input logic b, output logic r);
        waitClk(1);
        sdaPull <= ~b;
        waitClk(6);
        sclOut <= 1'b1;
        waitClk(4);
        r = sdaBus;
        waitClk(4);
        sclOut <= 1'b0;
    endtask
    // Also serves as the repeated start that keeps the bus between transfers.
    task automatic startCond();
        waitClk(1);
        sdaPull <= 1'b0;
        waitClk(6);
        sclOut <= 1'b1;
        waitClk(6);
        sdaPull <= 1'b1;
        waitClk(6);
        sclOut <= 1'b0;
    endtask
    task automatic stopCond();
        waitClk(1);
        sdaPull <= 1'b1;
        waitClk(6);
        sclOut <= 1'b1;
        waitClk(6);
        sdaPull <= 1'b0;
        waitClk(6);
    endtask
    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            busBit(d[i], r);
        end
        busBit(1'b1, r);
        ack = ~r;
    endtask
    task automatic recvByte(input logic ackIt, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            busBit(1'b1, d[i]);
        end
        busBit(~ackIt, r);
    endtask
endmodule

// ---- tb/qdr_slave_test.sv ----
// Self-checking bench for the quad DAC readback slave.
`timescale 1ns/1ps
module qdr_slave_test;
    import qdr_pkg::*;
    logic sys_clk, rst_n, sclBus, sdaPull, sdaOut, sdaOe, powerDownFlag;
    logic [1:0] hwAddr, chanSel, loadMode, extAddr;
    logic [31:0] chanData;
    logic [7:0] chanPwrdn;
    wire sdaBus;
    int errTotal = 0;
    int cmpCount = 0;
    assign sdaBus = ~(sdaPull | (sdaOe & ~sdaOut));
    always #50 sys_clk = ~sys_clk;
    qdr_master i_master (.sys_clk(sys_clk), .sdaBus(sdaBus), .sclOut(sclBus), .sdaPull(sdaPull));
    qdr_slave i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .sclIn(sclBus), .sdaIn(sdaBus), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .hwAddr(hwAddr), .chanData(chanData), .chanPwrdn(chanPwrdn), .chanSel(chanSel),
        .powerDownFlag(powerDownFlag), .loadMode(loadMode), .extAddr(extAddr));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errTotal++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        if (errTotal == 0 && cmpCount > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Flag clear: a third byte, read after acknowledging the low byte, must find the line released, which proves the count.
    task automatic readback(input logic [1:0] sel, input logic pd, input logic sr);
        logic ack;
        logic [7:0] d;
        i_master.startCond();
        i_master.sendByte({ADDR_FIXED, hwAddr, 1'b0}, ack);
        chk("write address ack", {7'h00, ack}, 8'h01);
        i_master.sendByte({sel, ~sel, 1'b0, sel, pd}, ack);
        chk("control ack", {7'h00, ack}, 8'h01);
        chk("control status", {1'b0, extAddr, loadMode, chanSel, powerDownFlag}, {1'b0, sel, ~sel, sel, pd});
        i_master.startCond();
        i_master.sendByte({ADDR_FIXED, hwAddr, 1'b1}, ack);
        chk("read address ack", {7'h00, ack}, 8'h01);
        if (pd) begin
            i_master.recvByte(1'b1, d);
            chk("power-down byte", d, {chanPwrdn[2*sel+:2], PD_FILL});
        end
        i_master.recvByte(1'b1, d);
        chk("high byte", d, chanData[8*sel+:8]);
        i_master.recvByte(~pd, d);
        if (!pd) begin
            i_master.recvByte(1'b0, d);
            chk("byte past end", d, 8'hFF);
        end
        i_master.waitClk(6);
        chk("released", {7'h00, sdaOe}, 8'h00);
        if (!sr) begin
            i_master.stopCond();
        end
    endtask
    task automatic wrongAddr();
        logic ack;
        i_master.startCond();
        i_master.sendByte({ADDR_FIXED, ~hwAddr, 1'b0}, ack);
        chk("foreign strap ack", {7'h00, ack}, 8'h00);
        i_master.startCond();
        i_master.sendByte({5'h12, hwAddr, 1'b0}, ack);
        chk("foreign prefix ack", {7'h00, ack}, 8'h00);
        i_master.stopCond();
    endtask
    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        hwAddr = 2'h2;
        chanData = 32'hC3A55A3C;
        chanPwrdn = 8'hE4;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk("reset status", {5'h00, chanSel, powerDownFlag}, 8'h00);
        for (int s = 0; s < 4; s++) begin
            readback(2'(s), 1'b0, 1'b0);
            readback(2'(s), 1'b1, s[0]);
        end
        wrongAddr();
        end_sim();
    end
    // Eight transfers need about seven thousand cycles; over five times that means a hang.
    initial begin
        repeat (40000) @(posedge sys_clk);
        errTotal++;
        end_sim();
    end
endmodule
